//--- test/hbpc_port_tb.sv
`timescale 1ns/1ps
module hbpc_port_tb;
    logic clk = 1'b0;
    logic line_clk = 1'b0;
    logic nrst = 1'b0;
    logic atm_uni_mode = 1'b0;
    logic hdlc_mode = 1'b0;
    logic tx_ext = 1'b0;
    logic rx_ext = 1'b0;
    logic rx_line_bit = 1'b0;
    logic rx_line_bit_en = 1'b0;
    logic tx_ready = 1'b0;
    logic send_en = 1'b0;
    logic tx_pin_o, tx_pin_oe, rx_pin_o, rx_pin_oe, snd_msg, tx_valid;
    logic plcp_nibble_stuff_ctl, plcp_frame_align_in;
    logic [hbpc_pkg::MSG_W-1:0] tx_msg_byte, rx_msg_byte, tx_data, rx_last;
    wire tx_pin;
    wire rx_pin;
    int rx_count;
    int fail_count = 0;
    int num_checks = 0;
    int cycles = 0;
    int ones = 0;

    always #5 clk = ~clk;
    initial begin
        #3.7;
        forever #7.5 line_clk = ~line_clk;
    end
    // Undriven pins follow the board level, held low outside ATM mode
    assign tx_pin = tx_pin_oe ? tx_pin_o : tx_ext;
    assign rx_pin = rx_pin_oe ? rx_pin_o : rx_ext;

    hbpc_port u_hbpc_port (.clk(clk), .nrst(nrst), .line_clk(line_clk),
        .atm_uni_mode(atm_uni_mode), .hdlc_mode(hdlc_mode), .tx_pin_i(tx_pin),
        .tx_pin_o(tx_pin_o), .tx_pin_oe(tx_pin_oe), .tx_msg_byte(tx_msg_byte),
        .snd_msg(snd_msg), .rx_pin_i(rx_pin), .rx_pin_o(rx_pin_o),
        .rx_pin_oe(rx_pin_oe), .rx_msg_byte(rx_msg_byte), .rx_line_bit(rx_line_bit),
        .rx_line_bit_en(rx_line_bit_en), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .plcp_nibble_stuff_ctl(plcp_nibble_stuff_ctl),
        .plcp_frame_align_in(plcp_frame_align_in));
    hbpc_term u_hbpc_term (.tx_clk_pin(tx_pin), .rx_clk_pin(rx_pin),
        .rx_msg_byte(rx_msg_byte), .tx_msg_byte(tx_msg_byte), .snd_msg(snd_msg),
        .send_en(send_en), .rx_last(rx_last), .rx_count(rx_count));

    task automatic results();
        $display("checks=%0d fails=%0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            fail_count++;
            results();
        end
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic clk_wait(input int n);
        repeat (n) @(negedge clk);
    endtask

    function automatic logic pin_lvl(input bit rx);
        return rx ? rx_pin_o : tx_pin_o;
    endfunction

    // Line cycles that the next full high phase of a pin clock lasts
    task automatic hi_width(input bit rx, output int n);
        int k;
        k = 0;
        n = 0;
        while (pin_lvl(rx) !== 1'b0 && k < 400) begin
            @(posedge line_clk);
            #1 k++;
        end
        while (pin_lvl(rx) !== 1'b1 && k < 400) begin
            @(posedge line_clk);
            #1 k++;
        end
        while (pin_lvl(rx) === 1'b1 && n < 20) begin
            @(posedge line_clk);
            #1 n++;
        end
    endtask

    task automatic test_tx();
        logic [7:0] prev;
        int n;
        int k;
        hdlc_mode = 1'b1;
        send_en = 1'b1;
        clk_wait(400);
        check(tx_pin_oe, 1'b1);
        check(tx_valid, 1'b1);
        n = 0;
        repeat (200) begin
            @(negedge clk);
            if (tx_pin_o !== 1'b0) n++;
        end
        check(8'(n), 8'h00);
        for (int i = 0; i < 6; i++) begin
            k = 0;
            while (tx_valid !== 1'b1 && k < 500) begin
                @(negedge clk);
                k++;
            end
            if (i > 0) check(tx_data, prev + 8'h01);
            prev = tx_data;
            tx_ready = 1'b1;
            @(negedge clk);
            tx_ready = 1'b0;
            @(negedge clk);
        end
        tx_ready = 1'b1;
        hi_width(1'b0, n);
        check(8'(n), 8'(hbpc_pkg::HALF_DIV));
        send_en = 1'b0;
        clk_wait(300);
        tx_ready = 1'b0;
        $display("test_tx done");
    endtask

    task automatic rx_bit(input logic b);
        @(negedge line_clk);
        rx_line_bit = b;
        rx_line_bit_en = 1'b1;
        @(negedge line_clk);
        rx_line_bit_en = 1'b0;
        rx_line_bit = ~b;
    endtask

    // Sends a byte first bit first, inserting a zero after five ones
    task automatic rx_send(input logic [7:0] b);
        for (int i = 0; i < 8; i++) begin
            rx_bit(b[i]);
            ones = b[i] ? ones + 1 : 0;
            if (ones == 5) begin
                rx_bit(1'b0);
                ones = 0;
            end
        end
    endtask

    task automatic test_rx();
        logic [7:0] vals [3] = '{8'hFF, 8'h3E, 8'h5A};
        int n;
        int c;
        foreach (vals[j]) begin
            c = rx_count;
            fork
                rx_send(vals[j]);
                hi_width(1'b1, n);
            join
            #1;
            check(8'(rx_count - c), 8'h01);
            check(rx_last, vals[j]);
            check(8'(n), 8'(hbpc_pkg::HALF_DIV));
        end
        $display("test_rx done");
    endtask

    task automatic test_modes();
        for (int m = 0; m < 4; m++) begin
            atm_uni_mode = m[1];
            hdlc_mode = m[0];
            tx_ext = m[1] & m[0];
            rx_ext = m[1] & ~m[0];
            clk_wait(40);
            check(tx_pin_oe, m == 1);
            check(rx_pin_oe, m == 1);
            check(plcp_nibble_stuff_ctl, m == 3);
            check(plcp_frame_align_in, m == 2);
        end
        tx_ext = 1'b0;
        rx_ext = 1'b0;
        $display("test_modes done");
    endtask

    initial begin
        clk_wait(8);
        nrst = 1'b1;
        clk_wait(10);
        test_tx();
        test_rx();
        test_modes();
        results();
    end
endmodule

//--- test/hbpc_term.sv
`timescale 1ns/1ps
module hbpc_term (
    // Pins as seen on the board
    input wire logic tx_clk_pin,
    input wire logic rx_clk_pin,
    input wire logic [hbpc_pkg::MSG_W-1:0] rx_msg_byte,
    // Transmit side toward the device
    output logic [hbpc_pkg::MSG_W-1:0] tx_msg_byte,
    output logic snd_msg,
    // Bench control and observation
    input wire logic send_en,
    output logic [hbpc_pkg::MSG_W-1:0] rx_last,
    output int rx_count
);
    initial begin
        tx_msg_byte = 8'h00;
        rx_last = 8'h00;
        rx_count = 0;
    end
    assign snd_msg = send_en;
    // Next byte placed on the bus at the demand clock rise
    always @(posedge tx_clk_pin) begin
        if (snd_msg) begin
            tx_msg_byte <= tx_msg_byte + 8'h01;
        end
    end
    always @(negedge rx_clk_pin) begin
        rx_last <= rx_msg_byte;
        rx_count <= rx_count + 1;
    end
endmodule

//--- verilog/hbpc_pkg.sv
// Notes on behaviour
// RL1: Pin role chosen from ATM and HDLC settings.
// RL2: HDLC mode drives transmit demand clock out.
// RL3: Send-message high: latch byte at clock fall.
// RL4: Equipment changes transmit byte at clock rise.
// RL5: Demand clock is line/8, edges may stall.
// RL6: Receive clock driven; byte changes at rise.
// RL7: Equipment samples receive byte at clock fall.
// RL8: Board holds clock pin low outside HDLC.
// RL9: ATM mode: transmit pin is nibble-stuff input.
// RL10: ATM mode: receive pin is 8 kHz align.
// RL11: Remove stuffed zeros; clock only full bytes.
package hbpc_pkg;
    localparam int MSG_W = 8;
    // Line clock divided by this gives the demand clock
    localparam int CLK_DIV = 8;
    localparam int HALF_DIV = CLK_DIV / 2;
    localparam logic [2:0] PH_FALL = 3'(HALF_DIV - 1);
    localparam logic [2:0] PH_LAST = 3'(CLK_DIV - 1);
    localparam logic [1:0] RX_HALF_LAST = 2'(HALF_DIV - 1);
    localparam logic [2:0] ONES_MAX = 3'h5;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [MSG_W-1:0] BYTE_RST = 8'h00;

    typedef enum logic [1:0] {RX_IDLE, RX_HIGH, RX_LOW} hbpc_rx_state_e;

    // Demand and receive clocks own their pins only in HDLC mode outside ATM
    function automatic logic hbpc_drives(input logic atm, input logic hdlc);
        return hdlc & ~atm;
    endfunction
endpackage

//--- verilog/hbpc_port.sv
`timescale 1ns/1ps
module hbpc_port #(
    parameter int DEPTH = 2
) (
    // System clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Line-rate clock for the pin-facing logic
    input wire logic line_clk,
    // Mode settings (clk domain, quasi-static)
    input wire logic atm_uni_mode,
    input wire logic hdlc_mode,
    // Transmit dual-role pin and message bus
    input wire logic tx_pin_i,
    output logic tx_pin_o,
    output logic tx_pin_oe,
    input wire logic [hbpc_pkg::MSG_W-1:0] tx_msg_byte,
    input wire logic snd_msg,
    // Receive dual-role pin and message bus
    input wire logic rx_pin_i,
    output logic rx_pin_o,
    output logic rx_pin_oe,
    output logic [hbpc_pkg::MSG_W-1:0] rx_msg_byte,
    // Received line bits (line_clk domain)
    input wire logic rx_line_bit,
    input wire logic rx_line_bit_en,
    // Transmit byte stream toward the framing engine (clk domain)
    output logic [hbpc_pkg::MSG_W-1:0] tx_data,
    output logic tx_valid,
    input wire logic tx_ready,
    // PLCP roles of the pins (clk domain)
    output logic plcp_nibble_stuff_ctl,
    output logic plcp_frame_align_in
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    initial begin
        if (DEPTH < 2) begin
            $error("DEPTH must be at least 2");
        end
    end

    // ---------------- Line domain ----------------
    logic lrst_s1_q;
    logic lrst_n_q;
    logic [1:0] lmode_s1_q;
    logic [1:0] lmode_q;
    logic [2:0] snd_s_q;
    logic snd_f_q;
    logic drive_l;

    // Reset release reaches the line domain through two stages
    always_ff @(posedge line_clk) begin
        lrst_s1_q <= nrst;
        lrst_n_q <= lrst_s1_q;
    end

    always_ff @(posedge line_clk) begin
        if (!lrst_n_q) begin
            lmode_s1_q <= 2'h0;
            lmode_q <= 2'h0;
        end else begin
            lmode_s1_q <= {atm_uni_mode, hdlc_mode};
            lmode_q <= lmode_s1_q;
        end
    end

    assign drive_l = hbpc_pkg::hbpc_drives(lmode_q[1], lmode_q[0]); // [RL1]
    assign tx_pin_oe = drive_l; // [RL2]
    assign rx_pin_oe = drive_l; // [RL6]

    // Send-message pin: three stages, change taken when stages two and three agree
    always_ff @(posedge line_clk) begin
        if (!lrst_n_q) begin
            snd_s_q <= 3'h0;
            snd_f_q <= 1'b0;
        end else begin
            snd_s_q <= {snd_s_q[1:0], snd_msg};
            if (snd_s_q[1] == snd_s_q[2]) begin
                snd_f_q <= snd_s_q[2];
            end
        end
    end

    logic [2:0] tx_ph_q;
    logic tx_clk_q;
    logic req_tgl_q;
    logic [1:0] ack_s_q;
    logic ack_tgl_q;
    logic busy;
    logic [hbpc_pkg::MSG_W-1:0] tx_hold_q;

    assign busy = req_tgl_q ^ ack_s_q[1];

    // Demand clock: four line cycles high, four low; held low while a byte is in flight
    always_ff @(posedge line_clk) begin
        if (!lrst_n_q || !drive_l) begin
            tx_ph_q <= hbpc_pkg::PH_LAST;
            tx_clk_q <= 1'b0;
        end else if (tx_ph_q == hbpc_pkg::PH_LAST) begin
            if (!busy) begin // [RL5]
                tx_ph_q <= 3'h0;
                tx_clk_q <= 1'b1; // [RL2]
            end
        end else begin
            tx_ph_q <= tx_ph_q + 3'h1;
            tx_clk_q <= (tx_ph_q < hbpc_pkg::PH_FALL); // [RL5]
        end
    end
    assign tx_pin_o = tx_clk_q;

    // Byte latched at the falling edge; equipment changes it at the rising edge
    always_ff @(posedge line_clk) begin
        if (!lrst_n_q) begin
            tx_hold_q <= hbpc_pkg::BYTE_RST;
            req_tgl_q <= 1'b0;
        end else if (drive_l && tx_ph_q == hbpc_pkg::PH_FALL && snd_f_q) begin // [RL3] [RL4]
            tx_hold_q <= tx_msg_byte;
            req_tgl_q <= ~req_tgl_q;
        end
    end

    always_ff @(posedge line_clk) begin
        if (!lrst_n_q) begin
            ack_s_q <= 2'h0;
        end else begin
            ack_s_q <= {ack_s_q[0], ack_tgl_q};
        end
    end

    // Receive: drop the zero after five ones, pack LSB first
    logic [2:0] ones_q;
    logic [2:0] bit_cnt_q;
    logic [hbpc_pkg::MSG_W-1:0] shf_q;
    logic [hbpc_pkg::MSG_W-1:0] pend_byte_q;
    logic pend_q;
    logic stuffed;
    logic byte_done;
    logic rx_load;
    logic rx_clk_q;
    logic [1:0] rx_cnt_q;
    hbpc_pkg::hbpc_rx_state_e rx_st_q;

    assign stuffed = (ones_q == hbpc_pkg::ONES_MAX) && !rx_line_bit;
    assign byte_done = rx_line_bit_en && !stuffed && (bit_cnt_q == hbpc_pkg::BIT_LAST);
    assign rx_load = (rx_st_q == hbpc_pkg::RX_IDLE) && pend_q && drive_l;

    always_ff @(posedge line_clk) begin
        if (!lrst_n_q) begin
            ones_q <= 3'h0;
            bit_cnt_q <= 3'h0;
            shf_q <= hbpc_pkg::BYTE_RST;
            pend_byte_q <= hbpc_pkg::BYTE_RST;
        end else if (rx_line_bit_en) begin
            if (stuffed) begin // [RL11]
                ones_q <= 3'h0;
            end else begin
                if (!rx_line_bit) begin
                    ones_q <= 3'h0;
                end else if (ones_q != hbpc_pkg::ONES_MAX) begin
                    ones_q <= ones_q + 3'h1;
                end
                shf_q <= {rx_line_bit, shf_q[hbpc_pkg::MSG_W-1:1]};
                bit_cnt_q <= bit_cnt_q + 3'h1;
                if (byte_done) begin
                    pend_byte_q <= {rx_line_bit, shf_q[hbpc_pkg::MSG_W-1:1]};
                end
            end
        end
    end

    // A completing byte wins over the hand-off that clears the flag
    always_ff @(posedge line_clk) begin
        if (!lrst_n_q) begin
            pend_q <= 1'b0;
        end else if (byte_done) begin
            pend_q <= 1'b1;
        end else if (rx_load) begin
            pend_q <= 1'b0;
        end
    end

    // Receive clock pulses only when a whole byte is waiting
    always_ff @(posedge line_clk) begin
        if (!lrst_n_q || !drive_l) begin
            rx_st_q <= hbpc_pkg::RX_IDLE;
            rx_clk_q <= 1'b0;
            rx_cnt_q <= 2'h0;
            // Leaving HDLC mode keeps the last byte, so data only moves with a clock rise
            if (!lrst_n_q) begin
                rx_msg_byte <= hbpc_pkg::BYTE_RST;
            end
        end else begin
            case (rx_st_q)
                hbpc_pkg::RX_IDLE: begin
                    if (rx_load) begin // [RL11]
                        rx_msg_byte <= pend_byte_q; // [RL6] [RL7]
                        rx_clk_q <= 1'b1;
                        rx_cnt_q <= 2'h0;
                        rx_st_q <= hbpc_pkg::RX_HIGH;
                    end
                end
                hbpc_pkg::RX_HIGH: begin
                    rx_cnt_q <= rx_cnt_q + 2'h1;
                    if (rx_cnt_q == hbpc_pkg::RX_HALF_LAST) begin
                        rx_clk_q <= 1'b0;
                        rx_cnt_q <= 2'h0;
                        rx_st_q <= hbpc_pkg::RX_LOW;
                    end
                end
                hbpc_pkg::RX_LOW: begin
                    rx_cnt_q <= rx_cnt_q + 2'h1;
                    if (rx_cnt_q == hbpc_pkg::RX_HALF_LAST) begin
                        rx_st_q <= hbpc_pkg::RX_IDLE;
                    end
                end
                default: begin
                    rx_st_q <= hbpc_pkg::RX_IDLE;
                    rx_clk_q <= 1'b0;
                end
            endcase
        end
    end
    assign rx_pin_o = rx_clk_q;

    // ---------------- System domain ----------------
    logic [1:0] req_s_q;
    logic req_seen_q;
    logic [hbpc_pkg::MSG_W-1:0] mem_q [DEPTH];
    logic [PW-1:0] wr_q;
    logic [PW-1:0] rd_q;
    logic [CW-1:0] cnt_q;
    logic full;
    logic push;
    logic pop;

    assign full = (cnt_q == CW'(DEPTH));
    assign push = (req_s_q[1] ^ req_seen_q) && !full;
    assign pop = tx_valid && tx_ready;
    assign tx_valid = (cnt_q != '0);
    assign tx_data = mem_q[rd_q];

    // Hold register is stable from toggle to acknowledge, so it is read directly
    always_ff @(posedge clk) begin
        if (!nrst) begin
            req_s_q <= 2'h0;
            req_seen_q <= 1'b0;
            ack_tgl_q <= 1'b0;
        end else begin
            req_s_q <= {req_s_q[0], req_tgl_q};
            if (push) begin
                req_seen_q <= req_s_q[1];
                ack_tgl_q <= ~ack_tgl_q;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                mem_q[wr_q] <= tx_hold_q;
                wr_q <= (wr_q == PW'(DEPTH - 1)) ? '0 : wr_q + PW'(1);
            end
            if (pop) begin
                rd_q <= (rd_q == PW'(DEPTH - 1)) ? '0 : rd_q + PW'(1);
            end
            case ({push, pop})
                2'b10: cnt_q <= cnt_q + CW'(1);
                2'b01: cnt_q <= cnt_q - CW'(1);
                default: cnt_q <= cnt_q;
            endcase
        end
    end

    // PLCP inputs: three stages, change taken when stages two and three agree
    logic [1:0] pin_s1_q;
    logic [1:0] pin_s2_q;
    logic [1:0] pin_s3_q;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            pin_s1_q <= 2'h0;
            pin_s2_q <= 2'h0;
            pin_s3_q <= 2'h0;
            plcp_nibble_stuff_ctl <= 1'b0;
            plcp_frame_align_in <= 1'b0;
        end else begin
            pin_s1_q <= {rx_pin_i, tx_pin_i};
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
            if (!atm_uni_mode) begin
                plcp_nibble_stuff_ctl <= 1'b0;
                plcp_frame_align_in <= 1'b0;
            end else begin
                if (pin_s2_q[0] == pin_s3_q[0]) begin
                    plcp_nibble_stuff_ctl <= pin_s3_q[0]; // [RL9]
                end
                if (pin_s2_q[1] == pin_s3_q[1]) begin
                    plcp_frame_align_in <= pin_s3_q[1]; // [RL10]
                end
            end
        end
    end

    // ---------------- Checks ----------------
    sequence s_tx_high;
        tx_clk_q [*4] ##1 !tx_clk_q;
    endsequence
    sequence s_rx_pulse;
        rx_clk_q [*4] ##1 !rx_clk_q [*4];
    endsequence

    property p_atm_no_drive;
        @(posedge line_clk) disable iff (!lrst_n_q) lmode_q[1] |-> !tx_pin_oe && !rx_pin_oe;
    endproperty
    a_atm_no_drive: assert property (p_atm_no_drive) else $error("pin driven in ATM mode"); // [RL1]
    property p_tx_period;
        // Leaving HDLC mode cuts a running pulse short on purpose
        @(posedge line_clk) disable iff (!lrst_n_q || !drive_l)
            $rose(tx_clk_q) |-> s_tx_high;
    endproperty
    a_tx_period: assert property (p_tx_period) else $error("demand clock high time wrong"); // [RL2]
    property p_tx_capture;
        @(posedge line_clk) disable iff (!lrst_n_q)
            (drive_l && tx_ph_q == hbpc_pkg::PH_FALL && snd_f_q)
            |=> (tx_hold_q == $past(tx_msg_byte)) && busy && !tx_clk_q;
    endproperty
    a_tx_capture: assert property (p_tx_capture) else $error("byte not latched at fall"); // [RL3]
    property p_tx_skip;
        @(posedge line_clk) disable iff (!lrst_n_q)
            (tx_ph_q == hbpc_pkg::PH_FALL && !snd_f_q) |=> $stable(req_tgl_q);
    endproperty
    a_tx_skip: assert property (p_tx_skip) else $error("byte latched without send"); // [RL3]
    property p_tx_withhold;
        @(posedge line_clk) disable iff (!lrst_n_q)
            (busy && tx_ph_q == hbpc_pkg::PH_LAST) |=> !tx_clk_q;
    endproperty
    a_tx_withhold: assert property (p_tx_withhold) else $error("edge issued while busy"); // [RL5]
    property p_rx_data_edge;
        @(posedge line_clk) disable iff (!lrst_n_q) $changed(rx_msg_byte) |-> $rose(rx_pin_o);
    endproperty
    a_rx_data_edge: assert property (p_rx_data_edge) else $error("rx byte moved off rise"); // [RL6]
    property p_rx_pulse;
        @(posedge line_clk) disable iff (!lrst_n_q || !drive_l)
            $rose(rx_clk_q) |-> $past(pend_q) ##0 s_rx_pulse;
    endproperty
    a_rx_pulse: assert property (p_rx_pulse) else $error("rx clock without byte"); // [RL11]
    property p_destuff;
        @(posedge line_clk) disable iff (!lrst_n_q)
            (rx_line_bit_en && stuffed) |=> $stable(bit_cnt_q) && ones_q == 3'h0;
    endproperty
    a_destuff: assert property (p_destuff) else $error("stuffed zero kept"); // [RL11]
    property p_plcp_off;
        @(posedge clk) disable iff (!nrst)
            !atm_uni_mode |=> !plcp_nibble_stuff_ctl && !plcp_frame_align_in;
    endproperty
    a_plcp_off: assert property (p_plcp_off) else $error("PLCP role outside ATM"); // [RL9]
    property p_align;
        @(posedge clk) disable iff (!nrst)
            (atm_uni_mode && pin_s2_q[1] == pin_s3_q[1])
            |=> plcp_frame_align_in == $past(pin_s3_q[1]);
    endproperty
    a_align: assert property (p_align) else $error("align input not followed"); // [RL10]
endmodule
